// *** hdl/atcw_apb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module atcw_apb_slave (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // bus
  input  wire atcw_pkg::atcw_apb_req_t req,
  output atcw_pkg::atcw_apb_rsp_t      rsp,
  // register side
  output logic                         wr_ctrl,
  output logic                         wr_word,
  output logic                         wr_shift,
  output logic [31:0]                  wdata,
  input  wire logic [31:0]             rd_ctrl,
  input  wire logic [31:0]             rd_word,
  input  wire logic [31:0]             rd_status
);
  import atcw_pkg::*;
  logic        access;
  logic        hit;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [11:0] a;

  assign a      = req.paddr[11:0];
  // zero-wait: answer in the first access cycle
  assign access = req.psel && req.penable;
  assign hit    = (req.paddr[31:12] == 20'h00000) &&
                  (a == ATCW_CTRL_ADDR || a == ATCW_WORD_ADDR ||
                   a == ATCW_STATUS_ADDR || a == ATCW_SHIFT_ADDR);
  assign wr_ctrl  = access && req.pwrite && a == ATCW_CTRL_ADDR && hit;
  assign wr_word  = access && req.pwrite && a == ATCW_WORD_ADDR && hit;
  assign wr_shift = access && req.pwrite && a == ATCW_SHIFT_ADDR && hit;
  assign wdata    = req.pwdata;

  always_comb begin
    case (a)
      ATCW_CTRL_ADDR:   rdata_d = rd_ctrl;
      ATCW_WORD_ADDR:   rdata_d = rd_word;
      ATCW_STATUS_ADDR: rdata_d = rd_status;
      default:          rdata_d = 32'h00000000;
    endcase
  end

  // read data registered in setup so it is stable for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (req.psel && !req.penable) begin
      prdata_q <= hit ? rdata_d : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= req.psel && !req.penable && !hit;
    end
  end

  assign rsp.prdata  = prdata_q;
  assign rsp.pready  = 1'b1;
  assign rsp.pslverr = pslverr_q;
endmodule
`default_nettype wire

// *** hdl/atcw_init_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module atcw_init_sel (
  // selectors
  input  wire logic       sel_a,
  input  wire logic       sel_b,
  // state code
  output logic [6:0]      init_code
);
  import atcw_pkg::*;
  always_comb begin
    case ({sel_a, sel_b})
      2'b11:   init_code = ATCW_INIT_BOTH;
      2'b10:   init_code = ATCW_INIT_A;
      2'b01:   init_code = ATCW_INIT_B;
      default: init_code = ATCW_INIT_NONE;
    endcase
  end
endmodule
`default_nettype wire

// *** hdl/atcw_pkg.sv ***
package atcw_pkg;

  localparam int ATCW_WORD_W = 7;

  // register byte addresses
  localparam logic [11:0] ATCW_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] ATCW_WORD_ADDR   = 12'h004;
  localparam logic [11:0] ATCW_STATUS_ADDR = 12'h008;
  localparam logic [11:0] ATCW_SHIFT_ADDR  = 12'h00C;

  // control register fields
  localparam int ATCW_CTRL_SERIAL_BIT = 0;
  localparam int ATCW_CTRL_STROBE_BIT = 1;
  localparam int ATCW_CTRL_SEL_A_BIT  = 2;
  localparam int ATCW_CTRL_SEL_B_BIT  = 3;
  localparam int ATCW_CTRL_WIDE_BIT   = 4;

  // status register fields
  localparam int ATCW_STAT_WORD_LSB = 0;
  localparam int ATCW_STAT_MODE_LSB = 8;
  localparam int ATCW_STAT_SEEN_BIT = 12;

  // control reset value: parallel, strobe low, selectors low, 7-bit
  localparam logic [4:0] ATCW_CTRL_RST = 5'h10;

  // initial state codes in quarter-dB steps
  localparam logic [6:0] ATCW_INIT_BOTH = 7'h7E;
  localparam logic [6:0] ATCW_INIT_A    = 7'h40;
  localparam logic [6:0] ATCW_INIT_B    = 7'h20;
  localparam logic [6:0] ATCW_INIT_NONE = 7'h00;
  localparam logic [6:0] ATCW_LSB_MASK  = 7'h7E;

  typedef enum logic [2:0] {
    ATCW_M_INIT    = 3'b000,
    ATCW_M_DIRECT  = 3'b001,
    ATCW_M_LATCHED = 3'b010,
    ATCW_M_SERIAL  = 3'b011
  } atcw_mode_t;

  typedef struct packed {
    logic serial_sel;
    logic strobe;
    logic sel_a;
    logic sel_b;
    logic wide;
  } atcw_ctrl_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } atcw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } atcw_apb_rsp_t;

endpackage

// *** hdl/atcw_top.sv ***
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module atcw_top #(
  parameter int WORD_W = atcw_pkg::ATCW_WORD_W
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb
  input  wire atcw_pkg::atcw_apb_req_t apb_req,
  output atcw_pkg::atcw_apb_rsp_t      apb_rsp,
  // control pins
  input  wire logic                    port_serial_sel,
  input  wire logic                    word_capture_strobe,
  input  wire logic                    initial_state_sel_a,
  input  wire logic                    initial_state_sel_b,
  input  wire logic [WORD_W-1:0]       attn_word_bits,
  // applied state
  output logic [WORD_W-1:0]            attn_weight_bits,
  output logic                         word_seen
);
  import atcw_pkg::*;

  atcw_ctrl_t  ctrl_q;
  logic        wr_ctrl;
  logic        wr_word;
  logic        wr_shift;
  logic [31:0] wdata;
  logic [6:0]  init_code;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] state_q;
  logic [WORD_W-1:0] state_d;
  logic        strobe_q;
  logic        seen_q;
  logic        seen_d;
  logic        serial_m;
  logic        strobe_m;
  logic        sel_a_m;
  logic        sel_b_m;
  logic [WORD_W-1:0] word_m;
  logic [WORD_W-1:0] lsb_mask;
  atcw_mode_t  mode_q;
  atcw_mode_t  mode_d;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_word;
  logic [31:0] rd_status;

  // narrow variant has no quarter-dB step
  function automatic logic [WORD_W-1:0] trim(input logic [WORD_W-1:0] w,
                                             input logic wide);
    trim = wide ? w : (w & WORD_W'(ATCW_LSB_MASK));
  endfunction

  atcw_apb_slave u_bus (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (apb_req),
    .rsp       (apb_rsp),
    .wr_ctrl   (wr_ctrl),
    .wr_word   (wr_word),
    .wr_shift  (wr_shift),
    .wdata     (wdata),
    .rd_ctrl   (rd_ctrl),
    .rd_word   (rd_word),
    .rd_status (rd_status)
  );

  // pins and software control are ored so either party can steer
  assign serial_m = port_serial_sel | ctrl_q.serial_sel;
  assign strobe_m = word_capture_strobe | ctrl_q.strobe;
  assign sel_a_m  = initial_state_sel_a | ctrl_q.sel_a;
  assign sel_b_m  = initial_state_sel_b | ctrl_q.sel_b;
  assign word_m   = trim(attn_word_bits | word_q, ctrl_q.wide);
  assign lsb_mask = WORD_W'(ATCW_LSB_MASK);

  atcw_init_sel u_init (
    .sel_a     (sel_a_m),
    .sel_b     (sel_b_m),
    .init_code (init_code)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // register bit order differs from struct order, so map field by field
      ctrl_q <= '{serial_sel: ATCW_CTRL_RST[ATCW_CTRL_SERIAL_BIT],
                  strobe:     ATCW_CTRL_RST[ATCW_CTRL_STROBE_BIT],
                  sel_a:      ATCW_CTRL_RST[ATCW_CTRL_SEL_A_BIT],
                  sel_b:      ATCW_CTRL_RST[ATCW_CTRL_SEL_B_BIT],
                  wide:       ATCW_CTRL_RST[ATCW_CTRL_WIDE_BIT]};
    end else if (wr_ctrl) begin
      ctrl_q.serial_sel <= wdata[ATCW_CTRL_SERIAL_BIT];
      ctrl_q.strobe     <= wdata[ATCW_CTRL_STROBE_BIT];
      ctrl_q.sel_a      <= wdata[ATCW_CTRL_SEL_A_BIT];
      ctrl_q.sel_b      <= wdata[ATCW_CTRL_SEL_B_BIT];
      ctrl_q.wide       <= wdata[ATCW_CTRL_WIDE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= '0;
    end else if (wr_word) begin
      word_q <= wdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_m;
    end
  end

  // serial shift path is not detailed; a full word written over the bus stands in
  always_comb begin
    state_d = state_q;
    seen_d  = seen_q;
    mode_d  = mode_q;
    if (serial_m) begin
      if (wr_shift) begin
        state_d = trim(wdata[WORD_W-1:0], ctrl_q.wide);
        seen_d  = 1'b1;
        mode_d  = ATCW_M_SERIAL;
      end else if (!seen_q) begin
        state_d = WORD_W'(init_code) & (ctrl_q.wide ? '1 : lsb_mask);
        mode_d  = ATCW_M_INIT;
      end
    end else if (strobe_m && strobe_q && seen_q && mode_q != ATCW_M_LATCHED) begin
      state_d = word_m;
      mode_d  = ATCW_M_DIRECT;
    end else if (strobe_m && !strobe_q) begin
      state_d = word_m;
      seen_d  = 1'b1;
      mode_d  = ATCW_M_LATCHED;
    end else if (strobe_m && mode_q == ATCW_M_LATCHED) begin
      state_d = word_m; // strobe held high keeps following
      mode_d  = ATCW_M_DIRECT;
    end else if (!strobe_m && !seen_q) begin
      state_d = WORD_W'(init_code);
      mode_d  = ATCW_M_INIT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
      seen_q  <= 1'b0;
      mode_q  <= ATCW_M_INIT;
    end else begin
      state_q <= state_d;
      seen_q  <= seen_d;
      mode_q  <= mode_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attn_weight_bits <= '0;
      word_seen        <= 1'b0;
    end else begin
      attn_weight_bits <= state_d;
      word_seen        <= seen_d;
    end
  end

  assign rd_ctrl = {27'h0000000, ctrl_q.wide, ctrl_q.sel_b, ctrl_q.sel_a,
                    ctrl_q.strobe, ctrl_q.serial_sel};
  assign rd_word = 32'(word_q);
  always_comb begin
    rd_status = 32'h00000000;
    rd_status[ATCW_STAT_WORD_LSB +: WORD_W] = state_q;
    rd_status[ATCW_STAT_MODE_LSB +: 3]      = mode_q;
    rd_status[ATCW_STAT_SEEN_BIT]           = seen_q;
  end
endmodule
`default_nettype wire

// *** verification/atcw_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module atcw_checker #(
  parameter int WORD_W = 7
) (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // bus
  input wire atcw_pkg::atcw_apb_req_t apb_req,
  input wire atcw_pkg::atcw_apb_rsp_t apb_rsp,
  // pins
  input wire logic                    port_serial_sel,
  input wire logic                    word_capture_strobe,
  input wire logic                    initial_state_sel_a,
  input wire logic                    initial_state_sel_b,
  input wire logic [WORD_W-1:0]       attn_word_bits,
  input wire logic [WORD_W-1:0]       attn_weight_bits,
  input wire logic                    word_seen
);
  import atcw_pkg::*;
  logic       pins_q;
  logic       par;
  logic       stb;
  logic [6:0] init_c;
  // registers are ORed with pins, so pin rules hold only until a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 1'b1;
    end else if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      pins_q <= 1'b0;
    end
  end
  assign par = pins_q && !port_serial_sel;
  assign stb = word_capture_strobe;
  assign init_c = initial_state_sel_a ? (initial_state_sel_b ? ATCW_INIT_BOTH : ATCW_INIT_A)
                                      : (initial_state_sel_b ? ATCW_INIT_B : ATCW_INIT_NONE);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_direct_follow: assert property (
    (par && stb && $stable(attn_word_bits))[*2] |=> attn_weight_bits == $past(attn_word_bits))
    else $error("direct word not applied");
  a_latch_capture: assert property (
    par && $rose(stb) |=> attn_weight_bits == $past(attn_word_bits))
    else $error("word not captured on strobe rise");
  a_latch_hold: assert property (
    (par && !stb && word_seen)[*2] |=> $stable(attn_weight_bits))
    else $error("state moved while strobe low");
  a_init_code: assert property (
    (par && !stb && !word_seen && $stable(init_c))[*2] |=> attn_weight_bits == $past(init_c))
    else $error("initial state code wrong");
  a_init_holds: assert property (
    par && !stb && !word_seen |=> !word_seen)
    else $error("word seen without a word");
  a_seen_sticky: assert property (
    word_seen |=> word_seen)
    else $error("word seen flag dropped");
  a_strobe_seen: assert property (
    (par && stb)[*2] |=> word_seen)
    else $error("strobe high did not leave initial state");
  a_apb_ready: assert property (
    apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("access without ready");
endmodule
bind atcw_top atcw_checker #(.WORD_W(WORD_W)) atcw_checker_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .port_serial_sel(port_serial_sel), .word_capture_strobe(word_capture_strobe),
  .initial_state_sel_a(initial_state_sel_a), .initial_state_sel_b(initial_state_sel_b),
  .attn_word_bits(attn_word_bits), .attn_weight_bits(attn_weight_bits), .word_seen(word_seen));
`default_nettype wire

// *** verification/atcw_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module atcw_ctrl_model (
  // clock
  input  wire logic  pclk,
  // control lines
  output logic       port_serial_sel,
  output logic       word_capture_strobe,
  output logic       initial_state_sel_a,
  output logic       initial_state_sel_b,
  output logic [6:0] attn_word_bits
);
  initial begin
    port_serial_sel = 1'b0;
    word_capture_strobe = 1'b0;
    initial_state_sel_a = 1'b0;
    initial_state_sel_b = 1'b0;
    attn_word_bits = 7'h00;
  end
  // all lines move together just after an edge, like a controller port
  task automatic drive(input logic s, st, a, b, input logic [6:0] w);
    @(posedge pclk);
    port_serial_sel <= s;
    word_capture_strobe <= st;
    initial_state_sel_a <= a;
    initial_state_sel_b <= b;
    attn_word_bits <= w;
  endtask
endmodule
`default_nettype wire

// *** verification/atcw_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module atcw_top_bench;
  import atcw_pkg::*;
  typedef struct packed {logic [6:0] word; logic [6:0] qdb;} atcw_row_t;
  logic          pclk, presetn, ser, stb, sa, sb, seen, err;
  logic [6:0]    word, attn;
  logic [31:0]   rd;
  atcw_apb_req_t req;
  atcw_apb_rsp_t rsp;
  int            error_cnt, n_tests, cyc;
  // expected in quarter-dB steps: sum of set weights
  atcw_row_t rows [10] = '{'{7'h00, 7'h00}, '{7'h01, 7'h01}, '{7'h02, 7'h02},
    '{7'h04, 7'h04}, '{7'h08, 7'h08}, '{7'h10, 7'h10}, '{7'h20, 7'h20},
    '{7'h40, 7'h40}, '{7'h7E, 7'h7E}, '{7'h7F, 7'h7F}};
  logic [6:0]    initc [4] = '{7'h00, 7'h20, 7'h40, 7'h7E};
  atcw_top #(.WORD_W(7)) atcw_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .port_serial_sel(ser), .word_capture_strobe(stb),
    .initial_state_sel_a(sa), .initial_state_sel_b(sb), .attn_word_bits(word),
    .attn_weight_bits(attn), .word_seen(seen));
  atcw_ctrl_model atcw_ctrl_model_inst (.pclk(pclk), .port_serial_sel(ser),
    .word_capture_strobe(stb), .initial_state_sel_a(sa), .initial_state_sel_b(sb),
    .attn_word_bits(word));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request stands until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [31:0] a, wd);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1 && cyc < 3000) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    presetn = 1'b0;
    req = '0;
    atcw_ctrl_model_inst.drive(0, 0, 1, 1, 7'h00);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      atcw_ctrl_model_inst.drive(0, 0, i[1], i[0], 7'h55);
      settle(3);
      chk("init", attn, initc[i]);
      chk("seen", seen, 1'b0);
    end
    foreach (rows[i]) begin
      atcw_ctrl_model_inst.drive(0, 1, 1, 1, rows[i].word);
      settle(2);
      chk("direct", attn, rows[i].qdb);
    end
    atcw_ctrl_model_inst.drive(0, 0, 1, 1, 7'h15);
    settle(3);
    chk("hold", attn, 7'h7F);
    atcw_ctrl_model_inst.drive(0, 1, 1, 1, 7'h33);
    atcw_ctrl_model_inst.drive(0, 0, 1, 1, 7'h0C);
    settle(3);
    chk("pulse", attn, 7'h33);
    apb(0, 32'h0000_0010, 0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    apb(0, ATCW_CTRL_ADDR, 0);
    chk("ctrl rst", rd, 32'h10);
    atcw_ctrl_model_inst.drive(1, 0, 1, 1, 7'h0C);
    apb(1, ATCW_SHIFT_ADDR, 32'h5A);
    settle(2);
    chk("serial", attn, 7'h5A);
    apb(0, ATCW_STATUS_ADDR, 0);
    chk("status", rd[12:0], 13'h135A);
    atcw_ctrl_model_inst.drive(0, 0, 1, 0, 7'h0C);
    presetn <= 1'b0;
    settle(2);
    chk("rst out", {seen, attn}, 8'h00);
    @(posedge pclk);
    presetn <= 1'b1;
    settle(3);
    chk("reinit", attn, 7'h40);
    apb(1, ATCW_CTRL_ADDR, 32'h0);
    apb(0, ATCW_CTRL_ADDR, 0);
    chk("ctrl wr", rd, 32'h0);
    atcw_ctrl_model_inst.drive(0, 1, 0, 0, 7'h7F);
    settle(2);
    chk("narrow", attn, 7'h7E);
    apb(1, ATCW_WORD_ADDR, 32'h11);
    atcw_ctrl_model_inst.drive(0, 1, 0, 0, 7'h00);
    settle(2);
    chk("word reg", attn, 7'h10);
    apb(0, ATCW_WORD_ADDR, 0);
    chk("word rd", rd, 32'h11);
    end_sim();
  end
endmodule
`default_nettype wire
